/* qie_defs.vh */
// constants for the quadrature index encoder receiver
// assumes a single 10 MHz clock and encoder pins that are asynchronous
//
// What this block does
// - one cycle is 360 electrical degrees; all phases use that unit.
// - the decoder counts one edge per cycle or four edges per cycle.
// - the receiver tracks 0 to 100000 cycles per second, including standstill.
// - the receiver takes any cycles_per_turn from 50 to 1250 as a parameter.
`ifndef QIE_DEFS_VH
`define QIE_DEFS_VH
`define QIE_CPT_DEFAULT 1250
`define QIE_CPT_MIN 50
`define QIE_CPT_MAX 1250
`define QIE_DEG_PER_CYCLE 360
`define QIE_MAX_CYCLE_RATE 100000
`define QIE_CLOCK_HZ 10000000
`define QIE_POS_WIDTH 13
`define QIE_MODE_SINGLE 1'h0
`define QIE_MODE_FOUR 1'h1
`define QIE_DIR_CW 1'h1
`define QIE_DIR_CCW 1'h0
`define QIE_EDGES_PER_CYCLE 4
`define QIE_PIN_A 0
`define QIE_PIN_B 1
`define QIE_PIN_M 2
`define QIE_PIN_COUNT 3
`define QIE_STEP_NONE 2'h0
`define QIE_STEP_BAD 2'h1
`define QIE_STEP_CCW 2'h2
`define QIE_STEP_CW 2'h3
`endif

/* qie_sync.v */
// three stage synchroniser for one asynchronous pin
// assumes pin may change at any time relative to clock
`timescale 1ns/100ps
module qie_sync (
	// clock and reset
	input wire clock,
	input wire rstn,
	// pin in, settled level out
	input wire pin,
	output reg level
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// change counts only once stages two and three agree
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end
endmodule

/* qie_decoder.v */
// quadrature decoder and position counter for an incremental encoder
// assumes encoder channels a, b and the turn marker arrive asynchronously
`timescale 1ns/100ps
`include "qie_defs.vh"
module qie_decoder #(
	parameter CYCLES_PER_TURN = `QIE_CPT_DEFAULT,
	parameter POS_WIDTH = `QIE_POS_WIDTH
) (
	// clock and reset
	input wire clock,
	input wire rstn,
	// encoder pins
	input wire channel_a,
	input wire channel_b,
	input wire once_per_turn_marker,
	// configuration
	input wire four_edge_decoding,
	input wire marker_clears,
	// results
	output reg [POS_WIDTH-1:0] position,
	output reg direction,
	output reg count_pulse,
	output reg marker_seen,
	output reg phase_error
);
	// out of range turn counts clamp, so the wrap fits any POS_WIDTH of 13 or more
	localparam integer CPT_LOW = (CYCLES_PER_TURN < `QIE_CPT_MIN) ?
		`QIE_CPT_MIN : CYCLES_PER_TURN;
	localparam integer CPT_USED = (CPT_LOW > `QIE_CPT_MAX) ?
		`QIE_CPT_MAX : CPT_LOW;
	// one count per quarter of the 360 degree cycle in four edge mode
	localparam integer CPT_X4 = CPT_USED * `QIE_EDGES_PER_CYCLE;
	localparam [31:0] LAST_X1_W = CPT_USED - 1;
	localparam [31:0] LAST_X4_W = CPT_X4 - 1;
	localparam [POS_WIDTH-1:0] LAST_X1 = LAST_X1_W[POS_WIDTH-1:0];
	localparam [POS_WIDTH-1:0] LAST_X4 = LAST_X4_W[POS_WIDTH-1:0];
	localparam [POS_WIDTH-1:0] ONE = {{(POS_WIDTH-1){1'h0}}, 1'h1};
	localparam [POS_WIDTH-1:0] ZERO = {POS_WIDTH{1'h0}};

	// raw pins and their settled copies, one bank entry per pin
	wire [`QIE_PIN_COUNT-1:0] pin_raw;
	wire [`QIE_PIN_COUNT-1:0] pin_sync;
	wire a_s;
	wire b_s;
	wire m_s;
	wire a_rise;
	wire marker_hit;
	reg a_reg;
	reg b_reg;
	reg m_reg;
	reg [1:0] step_code;
	reg step_raw;
	reg step;
	reg up;
	reg bad;
	reg [POS_WIDTH-1:0] last;
	reg [POS_WIDTH-1:0] pos_next;
	genvar gi;

	assign pin_raw[`QIE_PIN_A] = channel_a;
	assign pin_raw[`QIE_PIN_B] = channel_b;
	assign pin_raw[`QIE_PIN_M] = once_per_turn_marker;

	// banks may settle a clock apart; pins that change closer than
	// two clocks can then land in one sample as a phase error
	generate
		for (gi = 0; gi < `QIE_PIN_COUNT; gi = gi + 1) begin : g_sync
			qie_sync sync_pin (
				.clock(clock),
				.rstn(rstn),
				.pin(pin_raw[gi]),
				.level(pin_sync[gi])
			);
		end
	endgenerate

	assign a_s = pin_sync[`QIE_PIN_A];
	assign b_s = pin_sync[`QIE_PIN_B];
	assign m_s = pin_sync[`QIE_PIN_M];
	// single edge mode counts only this edge
	assign a_rise = a_s && !a_reg;
	// marker only counts while both channels are low
	assign marker_hit = m_s && !m_reg && !a_s && !b_s;

	// gray step direction from old and new state of a and b
	function [1:0] qie_step;
		input [1:0] old_ab;
		input [1:0] new_ab;
		begin
			case ({old_ab, new_ab})
			4'h2, 4'hb, 4'hd, 4'h4: qie_step = `QIE_STEP_CW;
			4'h1, 4'h7, 4'he, 4'h8: qie_step = `QIE_STEP_CCW;
			4'h3, 4'h6, 4'h9, 4'hc: qie_step = `QIE_STEP_BAD;
			default: qie_step = `QIE_STEP_NONE;
			endcase
		end
	endfunction

	// next count going up, wrapping at the end of a turn
	function [POS_WIDTH-1:0] qie_up;
		input [POS_WIDTH-1:0] pos;
		input [POS_WIDTH-1:0] top;
		begin
			if (pos >= top) begin
				qie_up = ZERO;
			end else begin
				qie_up = pos + ONE;
			end
		end
	endfunction

	function [POS_WIDTH-1:0] qie_down;
		input [POS_WIDTH-1:0] pos;
		input [POS_WIDTH-1:0] top;
		begin
			if (pos == ZERO) begin
				qie_down = top;
			end else begin
				qie_down = pos - ONE;
			end
		end
	endfunction

	// bit1 valid step, bit0 clockwise; code 01 means both changed
	always @* begin
		step_code = qie_step({a_reg, b_reg}, {a_s, b_s});
		step_raw = 1'h0;
		up = direction;
		bad = 1'h0;
		case (step_code)
		`QIE_STEP_CW: begin
			up = `QIE_DIR_CW;
			step_raw = 1'h1;
		end
		`QIE_STEP_CCW: begin
			up = `QIE_DIR_CCW;
			step_raw = 1'h1;
		end
		`QIE_STEP_BAD: begin
			bad = 1'h1;
		end
		default: begin
			step_raw = 1'h0;
		end
		endcase
	end

	// single edge mode keeps only the rising edge of a
	always @* begin
		step = step_raw;
		if (four_edge_decoding == `QIE_MODE_SINGLE) begin
			if (!a_rise) begin
				step = 1'h0;
			end
		end
	end

	always @* begin
		last = four_edge_decoding ? LAST_X4 : LAST_X1;
		pos_next = position;
		if (step) begin
			if (up == `QIE_DIR_CW) begin
				pos_next = qie_up(position, last);
			end else begin
				pos_next = qie_down(position, last);
			end
		end
		// a marker in the same cycle as a step wins
		if (marker_clears && marker_hit) begin
			pos_next = ZERO;
		end
	end

	// input history for the edge compare
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			a_reg <= 1'h0;
			b_reg <= 1'h0;
			m_reg <= 1'h0;
		end else begin
			a_reg <= a_s;
			b_reg <= b_s;
			m_reg <= m_s;
		end
	end

	// with no edges nothing moves, so standstill holds position
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			position <= ZERO;
			direction <= `QIE_DIR_CW;
		end else begin
			position <= pos_next;
			direction <= up;
		end
	end

	// one cycle strobe per counted edge
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_pulse <= 1'h0;
		end else begin
			count_pulse <= step;
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			marker_seen <= 1'h0;
		end else begin
			marker_seen <= marker_hit;
		end
	end

	// sticky until reset; a skipped state means lost counts
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			phase_error <= 1'h0;
		end else begin
			phase_error <= phase_error | bad;
		end
	end
endmodule

/* qie_props_properties.sv */
// assertions on the quadrature decoder ports
// assumes pin changes at least three clocks apart
`timescale 1ns/100ps
module qie_props #(
	parameter POS_WIDTH = 13
) (
	// clock and reset
	input wire clock,
	input wire rstn,
	// pins and mode
	input wire channel_a,
	input wire channel_b,
	input wire four_edge_decoding,
	input wire marker_clears,
	// results
	input wire [POS_WIDTH-1:0] position,
	input wire direction,
	input wire count_pulse,
	input wire marker_seen,
	input wire phase_error
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	pulse_single_a: assert property (count_pulse |=> !count_pulse)
		else $error("long count pulse");
	marker_single_a: assert property (marker_seen |=> !marker_seen)
		else $error("long marker pulse");
	error_sticky_a: assert property (phase_error |=> phase_error)
		else $error("error cleared");
	pos_hold_a: assert property (
		!count_pulse && !marker_clears |-> $stable(position))
		else $error("position moved");
	step_up_a: assert property (
		count_pulse && direction && !marker_clears |->
		position == $past(position) + 1'b1 || !position)
		else $error("bad forward step");
	step_down_a: assert property (
		count_pulse && !direction && !marker_clears |->
		position == $past(position) - 1'b1 || !$past(position))
		else $error("bad reverse step");
	a_rise_count_a: assert property (
		$rose(channel_a) && $stable(channel_b) |-> ##[3:6] count_pulse)
		else $error("rising a not counted");
	b_edge_count_a: assert property (
		$changed(channel_b) && $stable(channel_a) && four_edge_decoding
		|-> ##[3:6] count_pulse)
		else $error("b edge not counted");
	cover property (count_pulse && !direction);
	cover property (marker_seen && marker_clears);
	cover property (phase_error);
endmodule
bind qie_decoder qie_props #(.POS_WIDTH(POS_WIDTH)) props (.*);

/* qie_enc_model.sv */
// encoder model: two quadrature pins and a turn marker
// assumes step is called at a falling clock edge
`timescale 1ns/100ps
module qie_enc_model #(
	parameter N = 50
) (
	// encoder pins
	output reg a,
	output reg b,
	output reg mk
);
	integer ph = 0;
	integer old;
	initial {a, b, mk} = 3'h0;
	// equal quarter steps give 180 halves and 90 offset
	task step(input cw); begin
		old = ph;
		ph = cw ? (ph + 1) % (4 * N) : (ph + 4 * N - 1) % (4 * N);
		a = ph % 4 == 1 || ph % 4 == 2;
		b = ph % 4 > 1;
		// scheduled, so the caller's clock count is not disturbed
		if (ph == 0) mk <= #100 1'h1;
		else if (old == 0) mk <= #130 1'h0;
	end endtask
	task glitch; begin
		{a, b} = ~{a, b};
	end endtask
endmodule

/* testbench.sv */
// decoder bench driven by the encoder model
// assumes nine clocks between steps
`timescale 1ns/100ps
module testbench;
	reg clock = 0;
	reg rstn = 0;
	reg four = 0;
	reg clr = 0;
	wire a, b, mk, dir, cp, ms, pe;
	wire [12:0] pos;
	integer n_mismatch = 0;
	integer samples_checked = 0;
	integer n_mark = 0;
	integer n_count = 0;
	always #50 clock = ~clock;
	// pulses are counted half a clock after the edge that raises them
	always @(negedge clock) begin
		if (ms === 1'b1) n_mark = n_mark + 1;
		if (cp === 1'b1) n_count = n_count + 1;
	end
	qie_enc_model #(.N(50)) enc (.a(a), .b(b), .mk(mk));
	qie_decoder #(.CYCLES_PER_TURN(50)) dut (.clock(clock), .rstn(rstn),
		.channel_a(a), .channel_b(b), .once_per_turn_marker(mk),
		.four_edge_decoding(four), .marker_clears(clr), .position(pos),
		.direction(dir), .count_pulse(cp), .marker_seen(ms),
		.phase_error(pe));
	task check(input [12:0] got, input [12:0] exp); begin
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("[ERR] %0t got %0d want %0d", $time, got, exp);
		end
	end endtask
	task move(input cw, input integer n); begin
		repeat (n) begin
			@(negedge clock);
			enc.step(cw);
			repeat (8) @(negedge clock);
		end
	end endtask
	task t_single; begin
		n_count = 0;
		move(1, 8);
		check(pos, 13'h2);
		check(n_count[12:0], 13'h2);
	end endtask
	task t_cw; begin
		four = 1;
		n_count = 0;
		move(1, 4);
		check(pos, 13'h6);
		check(n_count[12:0], 13'h4);
		check({12'h0, dir}, 13'h1);
	end endtask
	// crosses zero, so the wrap is tested too; marker seen, not applied
	task t_ccw; begin
		n_mark = 0;
		n_count = 0;
		move(0, 14);
		check(pos, 13'h0c0);
		check(n_count[12:0], 13'h00e);
		check(n_mark[12:0], 13'h1);
		check({12'h0, dir}, 13'h0);
	end endtask
	task t_turn; begin
		clr = 1;
		n_mark = 0;
		move(1, 200);
		check(n_mark[12:0], 13'h1);
		check(pos, 13'h0c6);
	end endtask
	task t_glitch; begin
		enc.glitch;
		repeat (8) @(negedge clock);
		check({12'h0, pe}, 13'h1);
	end endtask
	// mid-run reset clears the sticky error; idle pins then hold still
	task t_reset; begin
		rstn = 0;
		repeat (2) @(negedge clock);
		check({12'h0, pe}, 13'h0);
		check(pos, 13'h0);
		check({12'h0, dir}, 13'h1);
		rstn = 1;
		repeat (8) @(negedge clock);
		check({12'h0, pe}, 13'h0);
		check(pos, 13'h0);
	end endtask
	task summarize; begin
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end endtask
	initial begin
		repeat (16) @(negedge clock);
		rstn = 1;
		t_single;
		t_cw;
		t_ccw;
		t_turn;
		t_glitch;
		t_reset;
		summarize;
	end
endmodule
